// >>> src/rtcc_ctrl.sv
// Calendar clock select, write lock, power windows, date and timestamp storage
// Summary of operation
// - Select field 00 picks secondary crystal ticks, 01 the low-power RC.
// - Select field 10 picks powerline ticks, 11 the system clock.
// - Stability window lasts count ticks; zero starts sampling on alarm.
// - Sample window lasts count ticks; all ones always open; zero none.
// - Sample window begins when stability timer expires, unless loaded zero.
// - Weekday digit sits in bits 2:0, limited to 0..6.
// - Timestamp date is free storage while disabled, kept across warm reset.
// - Lock blocks writes to calendar enable, second control and date.
// - Lock sets freely when clear and clears on presetn reset, not on por_n alone.
`timescale 1ns/1ps
module rtcc_ctrl
    import rtcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ref_ticks_t osc_ticks,
    input wire logic alarm_event,
    input wire logic ts_event,
    output logic ref_tick,
    output logic calendar_enable,
    output logic write_lock,
    output date_t date_out,
    output logic stab_window,
    output logic samp_window
);
    ctl_state_t c_r;
    ctl_state_t c_nxt;
    keep_state_t k_r;
    keep_state_t k_nxt;
    logic setup;
    logic wr;
    logic stab_win;
    logic samp_win;
    date_t wdate;

    localparam ctl_state_t CTL_RESET = '{
        calendar_enable_bit: 1'b0,
        write_lock_bit: 1'b0,
        power_window_enable: 1'b0,
        timestamp_a_enable: 1'b0,
        ref_clock_select: CLK_SEL_CRYSTAL,
        date: '0,
        key: KEY_IDLE,
        rdata: 32'h0000_0000,
        slverr: 1'b0,
        ref_tick: 1'b0
    };

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign wdate = '{day_tens_digit: pwdata[13:12], day_units_digit: pwdata[11:8],
        weekday_digit: pwdata[2:0]};

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_CTRL1) || (a == ADDR_CTRL2) || (a == ADDR_PWT)
            || (a == ADDR_KEY) || (a == ADDR_DATE) || (a == ADDR_TSA) || (a == ADDR_STAT);
    endfunction

    function automatic logic [31:0] read_mux(input logic [7:0] a, input ctl_state_t c,
        input keep_state_t k, input logic sw, input logic pw);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            ADDR_CTRL1:
            begin
                v[CTRL1_CAL_EN] = c.calendar_enable_bit;
                v[CTRL1_WLOCK] = c.write_lock_bit;
                v[CTRL1_PW_EN] = c.power_window_enable;
                v[CTRL1_TSA_EN] = c.timestamp_a_enable;
            end
            ADDR_CTRL2: v[1:0] = c.ref_clock_select;
            ADDR_PWT: v = {k.sample_window_count, k.stability_window_count};
            ADDR_DATE: v = pack_date(c.date);
            ADDR_TSA: v = k.tsa_date;
            ADDR_STAT: v[1:0] = {pw, sw};
            default: v = 16'h0000;
        endcase
        read_mux = {16'h0000, v};
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        c_nxt = c_r;
        k_nxt = k_r;
        c_nxt.ref_tick = sel_tick(c_r.ref_clock_select, osc_ticks);
        if (setup)
        begin
            c_nxt.rdata = read_mux(paddr, c_r, k_r, stab_win, samp_win);
            c_nxt.slverr = !addr_mapped(paddr);
        end
        if (wr)
        begin
            // Any write other than the expected key step drops the sequence
            c_nxt.key = KEY_IDLE;
            if (paddr == ADDR_KEY && pwdata[7:0] == UNLOCK_KEY_FIRST)
                c_nxt.key = KEY_ONE;
            else if (paddr == ADDR_KEY && c_r.key == KEY_ONE
                && pwdata[7:0] == UNLOCK_KEY_SECOND)
                c_nxt.key = KEY_TWO;
            unique case (paddr)
                ADDR_CTRL1:
                begin
                    c_nxt.power_window_enable = pwdata[CTRL1_PW_EN];
                    c_nxt.timestamp_a_enable = pwdata[CTRL1_TSA_EN];
                    if (!c_r.write_lock_bit)
                    begin
                        c_nxt.calendar_enable_bit = pwdata[CTRL1_CAL_EN];
                        c_nxt.write_lock_bit = pwdata[CTRL1_WLOCK];
                    end
                    else if (c_r.key == KEY_TWO && !pwdata[CTRL1_WLOCK])
                        c_nxt.write_lock_bit = 1'b0;
                end
                ADDR_CTRL2:
                    if (!c_r.write_lock_bit)
                        c_nxt.ref_clock_select = pwdata[1:0];
                ADDR_PWT:
                begin
                    k_nxt.sample_window_count = pwdata[15:8];
                    k_nxt.stability_window_count = pwdata[7:0];
                end
                ADDR_DATE:
                    // Out-of-range digits would corrupt the counting chain
                    if (!c_r.write_lock_bit && date_legal(wdate))
                        c_nxt.date = wdate;
                ADDR_TSA:
                    if (!c_r.timestamp_a_enable)
                        k_nxt.tsa_date = pwdata[15:0];
                default:
                begin
                end
            endcase
        end
        if (c_r.timestamp_a_enable && ts_event)
            k_nxt.tsa_date = pack_date(c_r.date);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            c_r <= CTL_RESET;
        else
            c_r <= c_nxt;
    end

    // Survives warm resets; only power-on clears it
    always_ff @(posedge pclk or negedge por_n)
    begin
        if (!por_n)
            k_r <= '{sample_window_count: WIN_CNT_RESET, stability_window_count: WIN_CNT_RESET,
                tsa_date: TSA_RESET};
        else
            k_r <= k_nxt;
    end

    // ----------------------------------------------------------------
    // Window sequencer on pclk, counting selected reference ticks
    // ----------------------------------------------------------------
    pw_window u_pw_window (
        .pclk(pclk),
        .presetn(presetn),
        .tick(c_r.ref_tick),
        .alarm(alarm_event),
        .enable(c_r.power_window_enable),
        .stab_cnt(k_r.stability_window_count),
        .samp_cnt(k_r.sample_window_count),
        .stab_win(stab_win),
        .samp_win(samp_win)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign prdata = c_r.rdata;
    assign pslverr = psel && penable && c_r.slverr;
    assign ref_tick = c_r.ref_tick;
    assign calendar_enable = c_r.calendar_enable_bit;
    assign write_lock = c_r.write_lock_bit;
    assign date_out = c_r.date;
    assign stab_window = stab_win;
    assign samp_window = samp_win;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !por_n);

    AST_CLK_SELECT: assert property (
        ##1 ref_tick == sel_tick($past(c_r.ref_clock_select), $past(osc_ticks)))
        else $error("reference tick not from selected source");
    AST_SYS_CLK: assert property (
        c_r.ref_clock_select == CLK_SEL_SYS && $past(c_r.ref_clock_select) == CLK_SEL_SYS
        |-> ref_tick)
        else $error("system clock select did not tick every cycle");
    AST_LOCK_BLOCKS: assert property (
        wr && write_lock && (paddr == ADDR_DATE || paddr == ADDR_CTRL2)
        |=> $stable(date_out) && $stable(c_r.ref_clock_select))
        else $error("locked write changed protected state");
    AST_LOCK_SET: assert property (
        wr && paddr == ADDR_CTRL1 && !write_lock && pwdata[CTRL1_WLOCK] |=> write_lock)
        else $error("lock did not set from clear");
    AST_UNLOCK: assert property (
        wr && paddr == ADDR_CTRL1 && write_lock && !pwdata[CTRL1_WLOCK]
        |=> write_lock == ($past(c_r.key) != KEY_TWO))
        else $error("lock clear not tied to key sequence");
    AST_DATE_LEGAL: assert property (
        date_legal(date_out))
        else $error("date digits out of range");
    AST_RSVD_ZERO: assert property (
        setup && paddr == ADDR_DATE |=> prdata[15:14] == 2'b00 && prdata[7:3] == 5'b00000)
        else $error("date reserved bits not zero");
    AST_TSA_STORE: assert property (
        wr && paddr == ADDR_TSA && !c_r.timestamp_a_enable |=> k_r.tsa_date == $past(pwdata[15:0]))
        else $error("timestamp storage write lost");
endmodule

// >>> src/rtcc_pkg.sv
// Shared constants, types and helpers for the calendar control block
package rtcc_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_PWT = 8'h08;
    localparam logic [7:0] ADDR_KEY = 8'h0c;
    localparam logic [7:0] ADDR_DATE = 8'h10;
    localparam logic [7:0] ADDR_TSA = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int CTRL1_CAL_EN = 15;
    localparam int CTRL1_WLOCK = 11;
    localparam int CTRL1_PW_EN = 10;
    localparam int CTRL1_TSA_EN = 0;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
    localparam logic [1:0] CLK_SEL_CRYSTAL = 2'b00;
    localparam logic [1:0] CLK_SEL_RC = 2'b01;
    localparam logic [1:0] CLK_SEL_LINE = 2'b10;
    localparam logic [1:0] CLK_SEL_SYS = 2'b11;
    localparam logic [7:0] WIN_CNT_ZERO = 8'h00;
    localparam logic [7:0] WIN_CNT_ONE = 8'h01;
    localparam logic [7:0] SAMP_ALWAYS = 8'hff;
    localparam logic [7:0] WIN_CNT_RESET = 8'h00;
    localparam logic [15:0] TSA_RESET = 16'h0000;
    localparam logic [1:0] DAY_TENS_MAX = 2'h3;
    localparam logic [3:0] DAY_UNITS_MAX = 4'h9;
    localparam logic [2:0] WEEKDAY_MAX = 3'h6;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] day_tens_digit;
        logic [3:0] day_units_digit;
        logic [2:0] weekday_digit;
    } date_t;

    typedef struct packed {
        logic secondary_crystal_osc;
        logic low_power_rc_osc;
        logic powerline;
    } ref_ticks_t;

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_ONE = 3'b010,
        KEY_TWO = 3'b100
    } key_state_t;

    typedef enum logic [2:0] {
        PW_IDLE = 3'b001,
        PW_STAB = 3'b010,
        PW_SAMP = 3'b100
    } pw_state_t;

    typedef struct packed {
        logic calendar_enable_bit;
        logic write_lock_bit;
        logic power_window_enable;
        logic timestamp_a_enable;
        logic [1:0] ref_clock_select;
        date_t date;
        key_state_t key;
        logic [31:0] rdata;
        logic slverr;
        logic ref_tick;
    } ctl_state_t;

    typedef struct packed {
        logic [7:0] sample_window_count;
        logic [7:0] stability_window_count;
        logic [15:0] tsa_date;
    } keep_state_t;

    typedef struct packed {
        pw_state_t st;
        logic [7:0] cnt;
    } pw_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] pack_date(input date_t d);
        pack_date = {2'b00, d.day_tens_digit, d.day_units_digit, 5'b00000, d.weekday_digit};
    endfunction

    function automatic logic date_legal(input date_t d);
        date_legal = (d.day_tens_digit <= DAY_TENS_MAX) && (d.day_units_digit <= DAY_UNITS_MAX)
            && (d.weekday_digit <= WEEKDAY_MAX);
    endfunction

    function automatic logic sel_tick(input logic [1:0] sel, input ref_ticks_t t);
        unique case (sel)
            CLK_SEL_CRYSTAL: sel_tick = t.secondary_crystal_osc;
            CLK_SEL_RC: sel_tick = t.low_power_rc_osc;
            CLK_SEL_LINE: sel_tick = t.powerline;
            CLK_SEL_SYS: sel_tick = 1'b1;
        endcase
    endfunction
endpackage

// >>> src/pw_window.sv
// Power-control stability and sample window sequencer
`timescale 1ns/1ps
module pw_window
    import rtcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic alarm,
    input wire logic enable,
    input wire logic [7:0] stab_cnt,
    input wire logic [7:0] samp_cnt,
    output logic stab_win,
    output logic samp_win
);
    pw_t s_r;
    pw_t s_nxt;
    logic samp_normal;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // All ones is a level, not a timed window
    assign samp_normal = (samp_cnt != WIN_CNT_ZERO) && (samp_cnt != SAMP_ALWAYS);

    always_comb
    begin
        s_nxt = s_r;
        unique case (s_r.st)
            PW_IDLE:
            begin
                if (enable && alarm)
                begin
                    if (stab_cnt != WIN_CNT_ZERO)
                    begin
                        s_nxt.st = PW_STAB;
                        s_nxt.cnt = stab_cnt;
                    end
                    else if (samp_normal)
                    begin
                        s_nxt.st = PW_SAMP;
                        s_nxt.cnt = samp_cnt;
                    end
                end
            end
            PW_STAB:
            begin
                if (!enable)
                    s_nxt.st = PW_IDLE;
                else if (tick && s_r.cnt == WIN_CNT_ONE)
                begin
                    s_nxt.st = samp_normal ? PW_SAMP : PW_IDLE;
                    s_nxt.cnt = samp_cnt;
                end
                else if (tick)
                    s_nxt.cnt = s_r.cnt - WIN_CNT_ONE;
            end
            PW_SAMP:
            begin
                if (!enable || (tick && s_r.cnt == WIN_CNT_ONE))
                    s_nxt.st = PW_IDLE;
                else if (tick)
                    s_nxt.cnt = s_r.cnt - WIN_CNT_ONE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '{st: PW_IDLE, cnt: 8'h00};
        else
            s_r <= s_nxt;
    end

    assign stab_win = (s_r.st == PW_STAB);
    // Always-open works even with power control off
    assign samp_win = (s_r.st == PW_SAMP) || (samp_cnt == SAMP_ALWAYS);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence fire_s;
        s_r.st == PW_IDLE && enable && alarm;
    endsequence

    sequence stab_end_s;
        s_r.st == PW_STAB && enable && tick && s_r.cnt == WIN_CNT_ONE;
    endsequence

    AST_STAB_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        fire_s ##0 (stab_cnt != WIN_CNT_ZERO) |=> stab_win && s_r.cnt == $past(stab_cnt))
        else $error("stability window not loaded on alarm");
    AST_STAB_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        fire_s ##0 (stab_cnt == WIN_CNT_ZERO && samp_normal) |=> !stab_win && samp_win)
        else $error("zero stability count did not start sample window");
    AST_STAB_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
        stab_end_s ##0 samp_normal |=> samp_win && !stab_win && s_r.cnt == $past(samp_cnt))
        else $error("sample window did not follow stability expiry");
    AST_SAMP_ALWAYS: assert property (@(posedge pclk) disable iff (!presetn)
        samp_cnt == SAMP_ALWAYS |-> samp_win)
        else $error("all-ones sample count not always open");
    AST_SAMP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        stab_end_s ##0 (samp_cnt == WIN_CNT_ZERO) |=> !samp_win && !stab_win)
        else $error("zero sample count opened a window");
endmodule

// >>> test/rtcc_ctrl_tb_top.sv
// Self-checking bench for the calendar control block
`timescale 1ns/1ps
module rtcc_ctrl_tb_top;
    import rtcc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ref_ticks_t osc_ticks = '0;
    logic alarm_event = 1'b0;
    logic ts_event = 1'b0;
    logic ref_tick;
    logic calendar_enable;
    logic write_lock;
    date_t date_out;
    logic stab_window;
    logic samp_window;
    int miscompares = 0;
    int num_checks = 0;
    logic [33:0] expq[$];
    logic [33:0] e;
    logic [31:0] seed = 32'h0000_004a;
    logic [31:0] t;
    logic [15:0] dv;
    int s;

    always #20 pclk = ~pclk;

    rtcc_ctrl rtcc_ctrl_i (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_ticks(osc_ticks),
        .alarm_event(alarm_event), .ts_event(ts_event), .ref_tick(ref_tick),
        .calendar_enable(calendar_enable), .write_lock(write_lock), .date_out(date_out),
        .stab_window(stab_window), .samp_window(samp_window));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task results();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Request held until pready seen high; expectation queued at setup
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        expq.push_back({w, err, d});
        @(posedge pclk);
        penable <= 1'b1;
        // No timeout here; pready seen high ends the wait, else the watchdog
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, x, 1'b0);
    endtask

    // Counts window cycles after one alarm; sample must follow stability at once
    task win(input logic [7:0] samp, input logic [7:0] stab, input int es, input int ep);
        int ns;
        int np;
        int ls;
        int fp;
        wr(ADDR_PWT, {16'h0, samp, stab});
        @(posedge pclk);
        alarm_event <= 1'b1;
        @(posedge pclk);
        alarm_event <= 1'b0;
        ns = 0;
        np = 0;
        ls = -1;
        fp = -1;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge pclk);
            if (stab_window === 1'b1)
            begin
                ns++;
                ls = i;
            end
            if (samp_window === 1'b1)
            begin
                np++;
                if (fp < 0)
                    fp = i;
            end
        end
        chk(ns, es);
        chk(np, ep);
        if (es > 0 && ep > 0)
            chk(fp, ls + 1);
    endtask

    // ------------------------------------------------------------
    // Output watcher: oldest note against each completed access
    // ------------------------------------------------------------
    always @(posedge pclk)
        if (psel && penable && pready)
        begin
            if (expq.size() == 0)
                chk(32'h1, 32'h0);
            else
            begin
                e = expq.pop_front();
                if (!e[33])
                    chk(prdata, e[31:0]);
                chk({31'h0, pslverr}, {31'h0, e[32]});
            end
        end

    // Hang guard, sized well above the expected run
    initial
    begin
        #(40 * 20000);
        miscompares++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        rd(ADDR_CTRL1, 32'h0);
        rd(ADDR_PWT, 32'h0);
        rd(ADDR_TSA, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, 1'b1);
        apb(1'b1, 8'h1c, 32'h5a5a, 1'b1);
        for (s = 0; s < 4; s++)
        begin
            wr(ADDR_CTRL2, s);
            rd(ADDR_CTRL2, s);
            repeat (4)
            begin
                t = rnd();
                @(posedge pclk);
                osc_ticks <= t[2:0];
                @(posedge pclk);
                osc_ticks <= '0;
                @(negedge pclk);
                chk({31'h0, ref_tick}, (s == 3) ? 32'h1 : {31'h0, t[2 - s]});
            end
        end
        repeat (3)
        begin
            t = rnd();
            dv = {2'b00, 2'(t[3:0] % 4), 4'(t[11:4] % 10), 5'h00, 3'(t[19:12] % 7)};
            wr(ADDR_DATE, {t[31:16], dv | 16'hc0f8});
            rd(ADDR_DATE, dv);
            chk({23'h0, date_out}, {23'h0, dv[13:8], dv[2:0]});
            wr(ADDR_DATE, {16'h0, dv[15:12], 4'ha, dv[7:0]});
            rd(ADDR_DATE, dv);
            wr(ADDR_DATE, {16'h0, dv[15:3], 3'h7});
            rd(ADDR_DATE, dv);
        end
        // Locked: calendar enable, select and date must not move
        wr(ADDR_CTRL1, 32'h8000);
        wr(ADDR_CTRL1, 32'h8800);
        @(negedge pclk);
        chk({31'h0, write_lock}, 32'h1);
        wr(ADDR_CTRL1, 32'h0800);
        wr(ADDR_CTRL2, 32'h0);
        wr(ADDR_DATE, 32'h0);
        rd(ADDR_CTRL1, 32'h8800);
        rd(ADDR_CTRL2, 32'h3);
        rd(ADDR_DATE, dv);
        chk({31'h0, calendar_enable}, 32'h1);
        wr(ADDR_KEY, 32'h55);
        wr(ADDR_PWT, 32'h0);
        wr(ADDR_KEY, 32'haa);
        wr(ADDR_CTRL1, 32'h8000);
        rd(ADDR_CTRL1, 32'h8800);
        // Unbroken key sequence, nothing between the three writes
        wr(ADDR_KEY, 32'h55);
        wr(ADDR_KEY, 32'haa);
        wr(ADDR_CTRL1, 32'h8400);
        rd(ADDR_CTRL1, 32'h8400);
        chk({31'h0, write_lock}, 32'h0);
        rd(ADDR_KEY, 32'h0);
        // Windows on the system clock reference, one tick per cycle
        win(8'h02, 8'h03, 3, 2);
        win(8'h02, 8'h00, 0, 2);
        win(8'h00, 8'h02, 2, 0);
        wr(ADDR_CTRL1, 32'h8000);
        wr(ADDR_PWT, 32'hff00);
        @(negedge pclk);
        chk({31'h0, samp_window}, 32'h1);
        rd(ADDR_STAT, 32'h2);
        // Storage survives warm reset; lock does not
        wr(ADDR_TSA, 32'hbeef);
        rd(ADDR_TSA, 32'hbeef);
        wr(ADDR_CTRL1, 32'h8800);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_TSA, 32'hbeef);
        rd(ADDR_PWT, 32'hff00);
        rd(ADDR_CTRL1, 32'h0);
        chk({31'h0, write_lock}, 32'h0);
        wr(ADDR_DATE, dv);
        wr(ADDR_CTRL1, 32'h1);
        wr(ADDR_TSA, 32'h0);
        rd(ADDR_TSA, 32'hbeef);
        @(posedge pclk);
        ts_event <= 1'b1;
        @(posedge pclk);
        ts_event <= 1'b0;
        rd(ADDR_TSA, dv);
        repeat (3) @(posedge pclk);
        results();
    end
endmodule
